//--- logic/ifc_pkg.sv
// Package of constants for the instruction fetch and cache block
package ifc_pkg;
   localparam int PC_W        = 17;            // Program counter width, words
   localparam int SEG_W       = 5;             // Segment number width
   localparam int OFS_W       = 12;            // Word offset inside a segment
   localparam int IDX_W       = 11;            // Cache index width
   localparam int TAG_W       = 4;             // Cache tag width
   localparam int ENTRIES     = 2048;          // Cache entries
   localparam int INSN_W      = 32;            // Instruction width
   localparam int ADDR_W      = 19;            // External byte address width
   localparam int SEG_SHIFT   = 14;            // Segment to byte address shift
   localparam int WORD_SHIFT  = 2;             // Word to byte address shift
   localparam logic [3:0] TAG_INIT = 4'hF;     // Tag value after initialisation
   localparam logic [16:0] PC_RESET = 17'h00000; // Program counter after reset
   localparam int MEM_RATIO   = 2;             // Core cycles per memory cycle
   localparam int PIPE_STAGES = 4;             // Fetch, decode, execute, store
   typedef enum logic [1:0] {IFC_INIT, IFC_RUN, IFC_MISS, IFC_FILL} ifc_state_e;
endpackage : ifc_pkg

//--- logic/ifc_tag_ram.sv
// Tag and instruction store of the direct-mapped instruction cache
`timescale 1ns/1ps
module ifc_tag_ram #(
   parameter int DEPTH = 2048,                 // Entries
   parameter int AW    = 11,                   // Index width
   parameter int TW    = 4,                    // Tag width
   parameter int DW    = 32                    // Data width
) (
   input  wire logic          clk,             // Core clock
   input  wire logic [AW-1:0] rdIdx,           // Lookup index
   output logic      [TW-1:0] rdTag,           // Tag at lookup index
   output logic      [DW-1:0] rdData,          // Instruction at lookup index
   input  wire logic          wrEn,            // Write strobe
   input  wire logic [AW-1:0] wrIdx,           // Write index
   input  wire logic [TW-1:0] wrTag,           // Tag to write
   input  wire logic [DW-1:0] wrData           // Instruction to write
);
   logic [TW-1:0] tagMem [DEPTH];              // Tag per entry, no valid bits
   logic [DW-1:0] dataMem [DEPTH];             // One instruction per line

   ////////////////////////////////////////////////////////////////////////////////
   // Asynchronous read keeps a hit to one cycle
   assign rdTag  = tagMem[rdIdx];
   assign rdData = dataMem[rdIdx];

   // Single-entry write per miss or per init step
   always_ff @(posedge clk) begin
      if (wrEn) begin
         tagMem[wrIdx]  <= wrTag;
         dataMem[wrIdx] <= wrData;
      end
   end
endmodule // ifc_tag_ram

//--- logic/ifc_fetch.sv
// Instruction fetch unit with program counter and direct-mapped cache
// Summary of operation
// - Program counter is seventeen bits wide
// - Feeds four-stage pipeline; decode stall handshake
// - One instruction per cycle unless stalled
// - Runs on doubled core clock
// - Thirty-two segments of 4K word-aligned instructions
// - 2048 direct-mapped entries, 4-bit tag, no valid
// - All tags set to ones at init
// - One-instruction line; miss replaces one entry
// - Tag names the 2K page within a 32K window
// - Cache disable fetches externally, never writes cache
// - Memory at half rate; uncached fetch stalls on every word
// - Tag match delivers in one cycle
// - Mismatch stalls, fetches, fills entry and tag
// - Byte address is segment<<14 plus offset<<2
// - Idle memory port shows program counter
// - Tags wrap every 32K instructions
// - Branch target is 12-bit in-segment word
// - Delayed branch keeps one issue per cycle
// - Target joins segment number and 12-bit field
`timescale 1ns/1ps
module ifc_fetch (
   input  wire logic        clk,               // Core clock, doubled rate
   input  wire logic        rst_b,             // Async reset, active low
   input  wire logic        cacheOff,          // Cache-disable bit
   input  wire logic [4:0]  segmentNumber,     // Segment base register segment
   input  wire logic        branchTake,        // Branch resolved taken
   input  wire logic [11:0] branchTarget,      // Branch target word field
   input  wire logic        decodeReady,       // Decode stage takes instruction
   output logic             insnValid,         // Instruction offered
   output logic [31:0]      insnData,          // Offered instruction
   output logic [16:0]      pcOut,             // Current program counter
   output logic             stall,             // Fetch stall to pipeline
   output logic [18:0]      memAddr,           // External byte address
   output logic             memRead,           // External read strobe
   input  wire logic [31:0] memData,           // External returned instruction
   output logic             initDone           // Cache tags initialised
);
   ifc_pkg::ifc_state_e stateQ;                // Fetch state
   logic [16:0] pcQ;                           // Program counter
   logic [16:0] pendQ;                         // Word address delayed branch uses
   logic        brPendQ;                       // Delayed branch waiting
   logic [10:0] initIdxQ;                      // Init sweep index
   logic        phaseQ;                        // Memory half-rate enable phase
   logic [16:0] missPcQ;                       // Address being fetched externally
   logic        missNcQ;                       // Miss taken with cache disabled
   logic [31:0] fillQ;                         // Returned instruction
   logic [31:0] insnQ;                         // Delivered instruction register
   logic        insnValidQ;                    // Delivered valid register
   logic [3:0]  rdTag;                         // Looked up tag
   logic [31:0] rdData;                        // Looked up instruction
   logic        ramWr;                         // Cache write
   logic [10:0] ramWrIdx;                      // Cache write index
   logic [3:0]  ramWrTag;                      // Cache write tag
   logic        hit;                           // Lookup hit
   logic        advance;                       // Program counter moves on
   logic [16:0] pcNext;                        // Next program counter
   logic        memEn;                         // Half-rate memory enable

   ////////////////////////////////////////////////////////////////////////////////
   // Cache store
   // Lookup is combinational so a hit costs no extra cycle
   ifc_tag_ram #(
      .DEPTH (ifc_pkg::ENTRIES),
      .AW    (ifc_pkg::IDX_W),
      .TW    (ifc_pkg::TAG_W),
      .DW    (ifc_pkg::INSN_W)
   ) uRam (
      .clk    (clk),
      .rdIdx  (pcQ[10:0]),
      .rdTag  (rdTag),
      .rdData (rdData),
      .wrEn   (ramWr),
      .wrIdx  (ramWrIdx),
      .wrTag  (ramWrTag),
      .wrData (fillQ)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Lookup and write steering
   // Tag is bits 14:11, so pages 32K apart alias; firmware must keep them apart
   assign hit = !cacheOff && (rdTag == pcQ[14:11]);
   assign ramWr    = (stateQ == ifc_pkg::IFC_INIT) ||
                     (stateQ == ifc_pkg::IFC_FILL && !missNcQ);
   assign ramWrIdx = (stateQ == ifc_pkg::IFC_INIT) ? initIdxQ : missPcQ[10:0];
   assign ramWrTag = (stateQ == ifc_pkg::IFC_INIT) ? ifc_pkg::TAG_INIT : missPcQ[14:11];
   // Memory slot every other core cycle, phase free running from reset
   assign memEn    = phaseQ;
   // Decode takes a word only on a hit or from the fill register
   assign advance  = decodeReady && ((stateQ == ifc_pkg::IFC_RUN && hit) ||
                                     stateQ == ifc_pkg::IFC_FILL);
   // Branch stays in segment; sequential flow may cross into the next one
   assign pcNext   = brPendQ ? pendQ : pcQ + 17'h00001;

   ////////////////////////////////////////////////////////////////////////////////
   // Half-rate enable divider
   // Free running, so a miss waits one or two cycles for its slot
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phaseQ <= 1'b0;
      end else begin
         phaseQ <= ~phaseQ;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fetch state machine
   // Only one miss is outstanding at a time, so no request queue
   // A fill refused by decode rewrites the same entry, which is harmless
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stateQ   <= ifc_pkg::IFC_INIT;
         initIdxQ <= 11'h000;
         missPcQ  <= ifc_pkg::PC_RESET;
         missNcQ  <= 1'b0;
         fillQ    <= 32'h00000000;
      end else begin
         unique case (stateQ)
            ifc_pkg::IFC_INIT: begin           // Sweep all tags to ones
               initIdxQ <= initIdxQ + 11'h001;
               if (initIdxQ == 11'h7FF) begin
                  stateQ <= ifc_pkg::IFC_RUN;
               end
            end
            ifc_pkg::IFC_RUN: begin
               if (!hit) begin                 // Miss or uncached
                  missPcQ <= pcQ;
                  missNcQ <= cacheOff;
                  stateQ  <= ifc_pkg::IFC_MISS;
               end
            end
            ifc_pkg::IFC_MISS: begin           // Wait for a memory slot
               if (memEn) begin
                  fillQ  <= memData;
                  stateQ <= ifc_pkg::IFC_FILL;
               end
            end
            ifc_pkg::IFC_FILL: begin           // Deliver and write one entry
               if (decodeReady) begin
                  stateQ <= ifc_pkg::IFC_RUN;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter and delayed branch
   // A branch seen during a stall waits in pendQ until the next delivery
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pcQ     <= ifc_pkg::PC_RESET;
         pendQ   <= ifc_pkg::PC_RESET;
         brPendQ <= 1'b0;
      end else begin
         if (branchTake) begin                 // Segment joined with target field
            pendQ   <= {segmentNumber, branchTarget};
            brPendQ <= 1'b1;
         end else if (advance) begin
            brPendQ <= 1'b0;
         end
         if (advance) begin
            pcQ <= pcNext;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Delivery registers
   // Valid is a one-cycle pulse; decode must take it while it stands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         insnQ      <= 32'h00000000;
         insnValidQ <= 1'b0;
      end else begin
         insnValidQ <= advance;
         if (advance) begin
            insnQ <= (stateQ == ifc_pkg::IFC_FILL) ? fillQ : rdData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs; memory address shows PC while idle
   // Counter on idle lines lets a probe follow code run from cache
   // Read strobe marks the one cycle in which memData is taken
   always_comb begin
      memRead = (stateQ == ifc_pkg::IFC_MISS) && memEn;
      if (stateQ == ifc_pkg::IFC_MISS) begin
         memAddr = {missPcQ[16:12], 14'h0000} + {5'h00, missPcQ[11:0], 2'h0};
      end else begin
         memAddr = {pcQ[16:12], 14'h0000} + {5'h00, pcQ[11:0], 2'h0};
      end
   end
   assign insnValid = insnValidQ;
   assign insnData  = insnQ;
   assign pcOut     = pcQ;
   assign stall     = !(stateQ == ifc_pkg::IFC_RUN && hit);
   assign initDone  = (stateQ != ifc_pkg::IFC_INIT);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   // All checks are quiet while reset is held
   sequence missStart_s;
      stateQ == ifc_pkg::IFC_RUN && !hit;
   endsequence
   sequence fillDone_s;
      ##[1:3] stateQ == ifc_pkg::IFC_FILL;
   endsequence

   missFill_a: assert property (@(posedge clk) disable iff (!rst_b)
      missStart_s |-> fillDone_s) else $error("miss did not reach fill");
   noCacheWr_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_FILL && missNcQ |-> !ramWr) else $error("uncached fill wrote cache");
   hitNoStall_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_RUN && hit && decodeReady |=> insnValid && insnData == $past(rdData))
      else $error("hit not delivered in one cycle");
   initTag_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_INIT |-> ramWr && ramWrTag == 4'hF) else $error("init tag not ones");
   idleAddr_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ != ifc_pkg::IFC_MISS |-> memAddr == {pcQ, 2'h0}) else $error("idle address not PC");
   halfRate_a: assert property (@(posedge clk) disable iff (!rst_b)
      memRead |=> !memRead) else $error("memory read at full rate");
   fillTag_a: assert property (@(posedge clk) disable iff (!rst_b)
      ramWr && stateQ == ifc_pkg::IFC_FILL |-> ramWrTag == missPcQ[14:11])
      else $error("fill tag wrong");
   branchTgt_a: assert property (@(posedge clk) disable iff (!rst_b)
      branchTake |=> brPendQ && pendQ == {$past(segmentNumber), $past(branchTarget)})
      else $error("branch target wrong");
   pcStep_a: assert property (@(posedge clk) disable iff (!rst_b)
      advance && !brPendQ |=> pcQ == $past(pcQ) + 17'h00001) else $error("pc did not step");

   ////////////////////////////////////////////////////////////////////////////////
   // Miss path checks, built from the steps of one external fetch
   // A miss first holds the address for one or two cycles, then fills
   sequence missWait_s;
      stateQ == ifc_pkg::IFC_MISS && stall && !insnValid;
   endsequence
   sequence fillTake_s;
      stateQ == ifc_pkg::IFC_FILL && decodeReady;
   endsequence

   // While waiting on memory nothing is offered and the pipeline is held
   missHold_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_MISS |-> missWait_s)
      else $error("miss did not hold the pipeline");

   // The external address during a miss is the fetched word times four
   missAddr_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_MISS |-> memAddr == {missPcQ, 2'h0})
      else $error("miss address wrong");

   // Filled word reaches decode one cycle after it is taken
   fillDeliver_a: assert property (@(posedge clk) disable iff (!rst_b)
      fillTake_s |=> insnValid && insnData == $past(fillQ))
      else $error("filled word not delivered");

   // Cached fill writes exactly the missed entry
   fillIdx_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_FILL && !missNcQ |-> ramWr && ramWrIdx == missPcQ[10:0])
      else $error("fill wrote wrong entry");

   // A miss never finishes before its memory slot
   missSlot_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_MISS ##1 stateQ == ifc_pkg::IFC_FILL |-> $past(memRead))
      else $error("fill without a memory read");

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter and control checks
   // Counter holds whenever nothing is handed to decode
   pcHold_a: assert property (@(posedge clk) disable iff (!rst_b)
      !advance |=> pcQ == $past(pcQ))
      else $error("pc moved without delivery");

   // The instruction after the slot comes from the branch target
   branchJump_a: assert property (@(posedge clk) disable iff (!rst_b)
      advance && brPendQ |=> pcQ == $past(pendQ))
      else $error("branch target not taken");

   // Uncached fetches never hit, whatever the tag holds
   uncachedMiss_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_RUN && cacheOff |=> stateQ == ifc_pkg::IFC_MISS)
      else $error("uncached fetch hit the cache");

   // Sweep ends after the last index and never restarts
   // Tag ones after the sweep means every first fetch misses unless its bits 14:11 are all ones
   sweepEnd_a: assert property (@(posedge clk) disable iff (!rst_b)
      stateQ == ifc_pkg::IFC_INIT && initIdxQ == 11'h7FF |=> initDone)
      else $error("sweep did not end");
   initStay_a: assert property (@(posedge clk) disable iff (!rst_b)
      initDone |=> initDone)
      else $error("sweep restarted");

   // Nothing is offered to decode before the tags are swept
   initQuiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      !initDone |-> !insnValid && stall && !memRead)
      else $error("activity during tag sweep");
endmodule // ifc_fetch

//--- tb/ifc_sram_model.sv
// Behavioural external instruction memory for the fetch block
`timescale 1ns/1ps
module ifc_sram_model (
   input  wire logic [18:0] memAddr,           // Byte address from fetch
   input  wire logic        memRead,           // Read strobe, sampled this cycle
   output logic      [31:0] memData            // Returned instruction
);
   logic [31:0] heldQ = 32'h0000_0000;         // Last word handed out

   ////////////////////////////////////////////////////////////////////////////////
   // Word content encodes its own byte address, so any wrong address shows
   // Outside a read the bus shows the inverse of the last word, never a stale copy
   always @(memRead or memAddr) begin
      if (memRead) begin
         memData = {8'hC3, 5'h00, memAddr};
         heldQ   = {8'hC3, 5'h00, memAddr};
      end else begin
         memData = ~heldQ;
      end
   end
endmodule // ifc_sram_model

//--- tb/ifc_fetch_bench.sv
// Self-checking testbench of the instruction fetch and cache block
`timescale 1ns/1ps
module ifc_fetch_bench;
   logic        clk, rst_b, cacheOff, branchTake, decodeReady;   // Bench drives
   logic [4:0]  segmentNumber;                  // Segment for branches
   logic [11:0] branchTarget;                   // Branch word field
   logic        insnValid, stall, memRead, initDone;            // Design flags
   logic [31:0] insnData, memData;              // Instruction paths
   logic [16:0] pcOut;                          // Program counter
   logic [18:0] memAddr;                        // External byte address
   int          mismatches = 0;                 // Failed comparisons
   int          compares   = 0;                 // All comparisons
   int          reads, gap;                     // Per-run measurements

   ifc_fetch dut_u (.clk(clk), .rst_b(rst_b), .cacheOff(cacheOff),
      .segmentNumber(segmentNumber), .branchTake(branchTake), .branchTarget(branchTarget),
      .decodeReady(decodeReady), .insnValid(insnValid), .insnData(insnData),
      .pcOut(pcOut), .stall(stall), .memAddr(memAddr), .memRead(memRead),
      .memData(memData), .initDone(initDone));
   ifc_sram_model mem_u (.memAddr(memAddr), .memRead(memRead), .memData(memData));

   ////////////////////////////////////////////////////////////////////////////////
   // 125 MHz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // One cycle; counts reads and checks the idle address shows the counter
   task automatic step();
      @(posedge clk);
      #1;
      if (memRead === 1'b1) reads++;
      else chk("idle address", {13'h0000, memAddr}, {13'h0000, pcOut, 2'b00});
   endtask

   // Bounded wait for the next delivered instruction
   task automatic next_insn();
      int i;
      for (i = 0; i < 60; i++) begin
         step();
         gap++;
         if (insnValid === 1'b1) return;
      end
      mismatches++;
      close_out();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and tag sweep length
   task automatic reset_check();
      int i;
      chk("pc at reset", {15'h0000, pcOut}, 32'h0000_0000);
      chk("valid at reset", {31'h0, insnValid}, 32'h0000_0000);
      @(posedge clk);
      rst_b <= 1'b1;
      // Sampled a step after each edge so the flag has settled
      for (i = 0; i < 2100 && initDone !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("sweep length", i, ifc_pkg::ENTRIES);
      if (initDone !== 1'b1) close_out();
   endtask

   // Delayed branch: the slot instruction passes, then the target follows
   task automatic branch_to(logic [4:0] seg, logic [11:0] word);
      logic [16:0] slot;                        // Word address of the delay slot
      @(posedge clk);
      decodeReady <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      slot = pcOut;
      @(posedge clk);
      segmentNumber <= seg;
      branchTarget  <= word;
      branchTake    <= 1'b1;
      @(posedge clk);
      branchTake  <= 1'b0;
      decodeReady <= 1'b1;
      next_insn();
      chk("delay slot", insnData, {8'hC3, 5'h00, slot, 2'b00});
   endtask

   // Delivers n words from w0; hit runs need no memory and no stall
   task automatic fetch_run(logic [16:0] w0, int n, bit hit);
      int k;
      reads = 0;
      for (k = 0; k < n; k++) begin
         next_insn();
         if (k == 0) begin
            reads = 0;
            gap   = 0;
         end
         if (k < n - 1) chk("stall", {31'h0, stall}, {31'h0, !hit});
         chk("instruction", insnData, {8'hC3, 5'h00, w0 + 17'(k), 2'b00});
      end
      if (hit) begin
         chk("hit reads", reads, 0);
         chk("hit cycles", gap, n - 1);
      end else begin
         chk("miss reads", (reads >= n - 1), 32'h0000_0001);
         chk("miss cycles", (gap >= 2 * (n - 1)), 32'h0000_0001);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: pages used all carry distinct tags below 0xF
   initial begin
      rst_b = 1'b0;
      cacheOff = 1'b0;
      branchTake = 1'b0;
      decodeReady = 1'b0;
      segmentNumber = 5'h00;
      branchTarget = 12'h000;
      repeat (20) @(posedge clk);
      reset_check();
      decodeReady <= 1'b1;
      fetch_run(17'h00000, 8, 1'b0);            // Cold fill, tag 0
      branch_to(5'h00, 12'h000);
      fetch_run(17'h00000, 8, 1'b1);            // Same page now hits
      cacheOff <= 1'b1;
      branch_to(5'h01, 12'h000);
      fetch_run(17'h01000, 4, 1'b0);            // uncached, same index other tag
      branch_to(5'h00, 12'h000);                // Slot still uncached, entry 4 kept
      cacheOff <= 1'b0;
      fetch_run(17'h00000, 8, 1'b1);            // entries left untouched
      branch_to(5'h01, 12'h805);
      fetch_run(17'h01805, 4, 1'b0);            // second page of segment
      branch_to(5'h01, 12'h805);
      fetch_run(17'h01805, 4, 1'b1);            // page now cached
      close_out();
   end
endmodule // ifc_fetch_bench
